// ===== common/emcp_defines.svh
// Constants for the external memory controller pin block.
// Assumes one clock domain and a client that issues one request at a time.
// Operation
// - Eight chip selects, one per external device.
// - Chip-select machine drives per-lane write enables.
// - Chip-select machine drives read output enable.
// - SDRAM machine drives eight lane mask outputs.
// - A10 is address on row, command on column.
// - SDRAM drives write, row and column strobes.
// - Pattern machine drives eight lane selects.
// - Six pattern lines follow the programmed pattern.
// - Wait input high stalls the pattern machine.
// - Transfer acknowledge input ends chip-select accesses.
// - Parity lane select acts as parity chip select.
// - External master mode drives SDRAM address mux.
// - External master mode strobes address latch enable.
// - Two buffer controls, function set by config.
// - Two burst address bits track beat address.
// - Single ends on one beat, burst on four.
`ifndef EMCP_DEFINES_SVH
`define EMCP_DEFINES_SVH
`define EMCP_LANES      8
`define EMCP_AW         32
`define EMCP_PAT_AW     6
`define EMCP_BURST_LEN  3'h4
`define EMCP_SD_RCD     4'h2
`define EMCP_SD_AUTOPRE 1'b1
`define EMCP_ROW_A10    10
`define EMCP_BURST_ADDR_OUT_LO   3
`define EMCP_BURST_ADDR_OUT_HI   4
`define EMCP_GPL_IDLE   6'h3f
`define EMCP_CFG_DIR    2'h0
`define EMCP_CFG_SPLIT  2'h1
`endif

// ===== common/emcp_pkg.sv
// Types shared by the external memory controller pin block.
// Assumes emcp_defines.svh is on the include path.
`include "emcp_defines.svh"
package emcp_pkg;
  // Machine that serves a request
  typedef enum logic [1:0] {
    M_GP = 2'h0,
    M_SD = 2'h1,
    M_PG = 2'h2
  } emcp_mach_t;
  // Controller states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_GP     = 6'h02,
    ST_SDROW  = 6'h04,
    ST_SDCOL  = 6'h08,
    ST_SDBEAT = 6'h10,
    ST_PG     = 6'h20
  } emcp_state_t;
  // One word of the programmed pattern
  typedef struct packed {
    logic       cs;   // Chip select asserted
    logic       bs;   // Lane selects asserted
    logic [5:0] gpl;  // Levels of the six pattern lines
    logic       wt;   // Sample the wait input here
    logic       beat; // One data beat completes here
    logic       last; // Pattern ends here
  } emcp_pat_t;
endpackage

// ===== rtl/emcp_lane.sv
// Byte-lane decoder: lanes touched by an access.
// Assumes lane 0 carries the lowest byte address of a double word.
`include "emcp_defines.svh"
module emcp_lane #(
  parameter int LANES = `EMCP_LANES
) (
  input  wire logic [2:0]       ADDR_LO,
  input  wire logic [1:0]       SIZE,
  input  wire logic [1:0]       PORT,
  output logic      [LANES-1:0] LANE_EN
);
  import emcp_pkg::*;
  logic [3:0] port_bytes; // Port width in bytes
  logic [3:0] size_bytes; // Transfer size in bytes
  logic [3:0] cnt;        // Bytes driven at once
  logic [3:0] off;        // First lane within the port

  // Sizes are powers of two: 1, 2, 4 or 8 bytes
  always_comb begin
    port_bytes = 4'h1 << PORT;
    size_bytes = 4'h1 << SIZE;
    cnt        = (size_bytes < port_bytes) ? size_bytes : port_bytes;
    off        = {1'b0, ADDR_LO} & (port_bytes - 4'h1);
  end

  // One compare per lane
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign LANE_EN[i] = (4'(i) >= off) && (4'(i) < off + cnt);
  end
endmodule

// ===== rtl/emcp_top.sv
// External memory controller pin sequencer: chip-select, SDRAM and
// pattern machines. Assumes requests come from on-chip logic one at a time
// and that the pattern memory is loaded before the pattern machine is used.
`include "emcp_defines.svh"
module emcp_top #(
  parameter int AW    = `EMCP_AW,
  parameter int PAT_N = 1 << `EMCP_PAT_AW
) (
  input  wire logic                         CLK,
  input  wire logic                         RESETN,
  input  wire logic                         REQ_VALID,
  output logic                              REQ_READY,
  input  wire emcp_pkg::emcp_mach_t         REQ_MACH,
  input  wire logic                         REQ_WRITE,
  input  wire logic                         REQ_BURST,
  input  wire logic [2:0]                   REQ_BANK,
  input  wire logic [AW-1:0]                REQ_ADDR,
  input  wire logic [1:0]                   REQ_SIZE,
  input  wire logic [1:0]                   REQ_PORT,
  input  wire logic [`EMCP_PAT_AW-1:0]      REQ_PAT_START,
  output logic                              BEAT_ACK,
  output logic                              REQ_DONE,
  input  wire logic                         PAT_WE,
  input  wire logic [`EMCP_PAT_AW-1:0]      PAT_ADDR,
  input  wire emcp_pkg::emcp_pat_t          PAT_DATA,
  input  wire logic                         EXT_MASTER,
  input  wire logic                         PARITY_EN,
  input  wire logic [1:0]                   BUFFER_CTRL_CFG,
  output logic [7:0]                        CS_N,
  output logic [7:0]                        GP_WRITE_LANE_N,
  output logic                              GP_READ_ENABLE_N,
  input  wire logic                         GP_XFER_ACK_IN_N,
  output logic [7:0]                        SDRAM_LANE_MASK,
  output logic                              SDRAM_ADDR_BIT10,
  output logic                              SDRAM_WRITE_N,
  output logic                              SDRAM_ROW_STROBE_N,
  output logic                              SDRAM_COL_STROBE_N,
  output logic                              SDRAM_ADDR_MUX_SEL,
  output logic [7:0]                        PROG_LANE_SELECT_N,
  output logic                              PROG_LINE_0,
  output logic                              PROG_LINE_1,
  output logic                              PROG_LINE_2,
  output logic                              PROG_LINE_3,
  output logic                              PROG_LINE_4,
  output logic                              PROG_LINE_5,
  input  wire logic                         PROG_WAIT_IN,
  output logic                              PARITY_LANE_SELECT_N,
  output logic                              ADDR_LATCH_EN,
  output logic                              BUFFER_CTRL_A,
  output logic                              BUFFER_CTRL_B,
  output logic [1:0]                        BURST_ADDR_OUT
);
  import emcp_pkg::*;

  // Whole controller state, pins included
  typedef struct packed {
    emcp_state_t                st;
    logic [2:0]                 bank;
    logic                       wr;
    logic                       burst;
    logic [AW-1:0]              addr;
    logic [1:0]                 size;
    logic [1:0]                 port;
    logic [2:0]                 nbeat;  // Beats finished so far
    logic [3:0]                 cnt;    // Row-to-column delay
    logic [`EMCP_PAT_AW-1:0]    ptr;    // Pattern word in use
    logic                       beat_ack;
    logic                       done;
    logic [7:0]                 cs_n;
    logic [7:0]                 we_n;
    logic                       oe_n;
    logic [7:0]                 dqm;
    logic                       a10;
    logic                       sdwe_n;
    logic                       ras_n;
    logic                       cas_n;
    logic                       amux;
    logic [7:0]                 bs_n;
    logic [5:0]                 gpl;
    logic                       pbs_n;
    logic                       ale;
    logic                       bca;
    logic                       bcb;
    logic [1:0]                 burst_addr_out;
  } emcp_reg_t;

  // Reset image: every pin at its inactive level, buffer controls at their DIR config idle levels
  localparam emcp_reg_t RST = '{
    st: ST_IDLE, cs_n: 8'hff, we_n: 8'hff, oe_n: 1'b1, dqm: 8'hff,
    sdwe_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, bs_n: 8'hff,
    gpl: `EMCP_GPL_IDLE, pbs_n: 1'b1, bcb: 1'b1, default: '0};

  emcp_reg_t     q;          // Registered state
  emcp_reg_t     d;          // Next state
  emcp_pat_t     pat [PAT_N]; // Programmed pattern memory
  emcp_pat_t     pw_q;       // Pattern word being executed
  emcp_pat_t     pw_d;       // Pattern word about to be executed
  logic [7:0]    lanes;      // Lanes touched by the access
  logic [2:0]    l_addr;     // Lane decoder address source
  logic [1:0]    l_size;     // Lane decoder size source
  logic [1:0]    l_port;     // Lane decoder port source
  logic          last;       // Current beat is the final one
  logic          in_acc;     // An access is under way next cycle

  // Pattern memory load port
  always_ff @(posedge CLK) begin
    if (PAT_WE) begin
      pat[PAT_ADDR] <= PAT_DATA;
    end
  end

  // Lane decode uses the request until it is latched
  assign l_addr = (q.st == ST_IDLE) ? REQ_ADDR[2:0] : q.addr[2:0];
  assign l_size = (q.st == ST_IDLE) ? REQ_SIZE : q.size;
  assign l_port = (q.st == ST_IDLE) ? REQ_PORT : q.port;

  emcp_lane #(
    .LANES   (8)
  ) u_lane (
    .ADDR_LO (l_addr),
    .SIZE    (l_size),
    .PORT    (l_port),
    .LANE_EN (lanes)
  );

  assign pw_q = pat[q.ptr];
  // Burst ends on its fourth beat, a single on its first
  assign last = q.burst ? (q.nbeat == `EMCP_BURST_LEN - 3'h1) : 1'b1;

  // Sequencing, then pin levels derived from the next state
  always_comb begin
    d          = q;
    d.beat_ack = 1'b0;
    d.done     = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        // Latch a new request
        if (REQ_VALID) begin
          d.bank  = REQ_BANK;
          d.wr    = REQ_WRITE;
          d.burst = REQ_BURST;
          d.addr  = REQ_ADDR;
          d.size  = REQ_SIZE;
          d.port  = REQ_PORT;
          d.nbeat = 3'h0;
          d.cnt   = `EMCP_SD_RCD;
          d.ptr   = REQ_PAT_START;
          case (REQ_MACH)
            M_SD:    d.st = ST_SDROW;
            M_PG:    d.st = ST_PG;
            default: d.st = ST_GP;
          endcase
        end
      end
      ST_GP: begin
        // External acknowledge finishes each beat
        if (!GP_XFER_ACK_IN_N) begin
          d.beat_ack = 1'b1;
          d.nbeat    = q.nbeat + 3'h1;
          if (last) begin
            d.st   = ST_IDLE;
            d.done = 1'b1;
          end
        end
      end
      ST_SDROW: begin
        // Hold off the column command for the row delay
        if (q.cnt <= 4'h1) begin
          d.st = ST_SDCOL;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      ST_SDCOL: begin
        d.st = ST_SDBEAT;
      end
      ST_SDBEAT: begin
        // One beat per cycle
        d.beat_ack = 1'b1;
        d.nbeat    = q.nbeat + 3'h1;
        if (last) begin
          d.st   = ST_IDLE;
          d.done = 1'b1;
        end
      end
      ST_PG: begin
        // A raised wait input freezes the pattern
        if (!(pw_q.wt && PROG_WAIT_IN)) begin
          if (pw_q.beat) begin
            d.beat_ack = 1'b1;
            d.nbeat    = q.nbeat + 3'h1;
          end
          if (pw_q.last || (pw_q.beat && last)) begin
            d.st   = ST_IDLE;
            d.done = 1'b1;
          end else begin
            d.ptr = q.ptr + 1'b1;
          end
        end
      end
    endcase

    pw_d   = pat[d.ptr]; // Word that the next cycle executes, read here to keep the loop local
    in_acc = (d.st != ST_IDLE);
    // Chip select of the addressed bank
    d.cs_n = 8'hff;
    if (in_acc && !(d.st == ST_PG && !pw_d.cs)) begin
      d.cs_n[d.bank] = 1'b0;
    end
    // Chip-select machine strobes
    d.we_n = (d.st == ST_GP && d.wr) ? ~lanes : 8'hff;
    d.oe_n = !(d.st == ST_GP && !d.wr);
    // SDRAM command: activate on entry, then column command
    d.ras_n  = !(d.st == ST_SDROW && q.st == ST_IDLE);
    d.cas_n  = !(d.st == ST_SDCOL);
    d.sdwe_n = !(d.st == ST_SDCOL && d.wr);
    if (!d.ras_n) begin
      d.a10 = d.addr[`EMCP_ROW_A10];
    end else if (!d.cas_n) begin
      d.a10 = `EMCP_SD_AUTOPRE;
    end else begin
      d.a10 = 1'b0;
    end
    // SDRAM lane masks are high for unused lanes
    d.dqm  = (d.st == ST_SDCOL || d.st == ST_SDBEAT) ? ~lanes : 8'hff;
    d.amux = EXT_MASTER && (d.st == ST_SDCOL || d.st == ST_SDBEAT);
    // Pattern machine lines
    d.bs_n = (d.st == ST_PG && pw_d.bs) ? ~lanes : 8'hff;
    d.gpl  = (d.st == ST_PG) ? pw_d.gpl : `EMCP_GPL_IDLE;
    // Parity chip follows whichever lane strobe is active
    d.pbs_n = !(PARITY_EN && (d.we_n != 8'hff || !d.oe_n || d.bs_n != 8'hff));
    // Address latch strobe in the first cycle of an access
    d.ale = EXT_MASTER && in_acc && q.st == ST_IDLE;
    // Data buffer controls
    if (BUFFER_CTRL_CFG == `EMCP_CFG_SPLIT) begin
      d.bca = !(in_acc && !d.wr);
      d.bcb = !(in_acc && d.wr);
    end else begin
      d.bca = in_acc && d.wr;
      d.bcb = !in_acc;
    end
    // Beat address within the burst
    d.burst_addr_out = in_acc ? d.addr[`EMCP_BURST_ADDR_OUT_HI:`EMCP_BURST_ADDR_OUT_LO] + d.nbeat[1:0] : 2'h0;
  end

  // State register
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // Pins from flip-flops
  assign REQ_READY            = (q.st == ST_IDLE);
  assign BEAT_ACK             = q.beat_ack;
  assign REQ_DONE             = q.done;
  assign CS_N                 = q.cs_n;
  assign GP_WRITE_LANE_N      = q.we_n;
  assign GP_READ_ENABLE_N     = q.oe_n;
  assign SDRAM_LANE_MASK      = q.dqm;
  assign SDRAM_ADDR_BIT10     = q.a10;
  assign SDRAM_WRITE_N        = q.sdwe_n;
  assign SDRAM_ROW_STROBE_N   = q.ras_n;
  assign SDRAM_COL_STROBE_N   = q.cas_n;
  assign SDRAM_ADDR_MUX_SEL   = q.amux;
  assign PROG_LANE_SELECT_N   = q.bs_n;
  assign PROG_LINE_0          = q.gpl[0];
  assign PROG_LINE_1          = q.gpl[1];
  assign PROG_LINE_2          = q.gpl[2];
  assign PROG_LINE_3          = q.gpl[3];
  assign PROG_LINE_4          = q.gpl[4];
  assign PROG_LINE_5          = q.gpl[5];
  assign PARITY_LANE_SELECT_N = q.pbs_n;
  assign ADDR_LATCH_EN        = q.ale;
  assign BUFFER_CTRL_A        = q.bca;
  assign BUFFER_CTRL_B        = q.bcb;
  assign BURST_ADDR_OUT       = q.burst_addr_out;

  // At most one chip select at a time
  property p_cs_one;
    @(posedge CLK) disable iff (!RESETN) $countones(~CS_N) <= 1;
  endproperty
  a_cs_one: assert property (p_cs_one) else $error("two chip selects");

  // Write lanes only with a chip select and never with read enable
  property p_we_lane;
    @(posedge CLK) disable iff (!RESETN)
      GP_WRITE_LANE_N != 8'hff |-> CS_N != 8'hff && GP_READ_ENABLE_N;
  endproperty
  a_we_lane: assert property (p_we_lane) else $error("stray write lane");

  // Read enable only inside a read access
  property p_oe_rd;
    @(posedge CLK) disable iff (!RESETN)
      !GP_READ_ENABLE_N |-> q.st == ST_GP && !q.wr;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("read enable outside read");

  // Column command follows activate after the row delay
  property p_ras_cas;
    @(posedge CLK) disable iff (!RESETN)
      !SDRAM_ROW_STROBE_N |-> SDRAM_COL_STROBE_N [*2] ##1 !SDRAM_COL_STROBE_N;
  endproperty
  a_ras_cas: assert property (p_ras_cas) else $error("column timing wrong");

  // A10 carries the command bit with the column strobe
  property p_a10;
    @(posedge CLK) disable iff (!RESETN)
      !SDRAM_COL_STROBE_N |-> SDRAM_ADDR_BIT10 == `EMCP_SD_AUTOPRE && $past(SDRAM_ROW_STROBE_N);
  endproperty
  a_a10: assert property (p_a10) else $error("A10 wrong on column");

  // A stalled pattern keeps its word and lines
  property p_wait;
    @(posedge CLK) disable iff (!RESETN)
      q.st == ST_PG && pw_q.wt && PROG_WAIT_IN |=> $stable(q.ptr) && $stable(q.gpl);
  endproperty
  a_wait: assert property (p_wait) else $error("pattern moved under wait");

  // Final acknowledge releases the chip select next cycle
  property p_ack_end;
    @(posedge CLK) disable iff (!RESETN)
      q.st == ST_GP && !GP_XFER_ACK_IN_N && last |=> REQ_DONE && CS_N == 8'hff;
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("access not ended");

  // Done comes with the fourth or the only beat
  property p_beats;
    @(posedge CLK) disable iff (!RESETN)
      REQ_DONE |-> BEAT_ACK && q.nbeat == (q.burst ? `EMCP_BURST_LEN : 3'h1);
  endproperty
  a_beats: assert property (p_beats) else $error("beat count wrong");

  // Burst address steps with each beat
  property p_burst_addr_out;
    @(posedge CLK) disable iff (!RESETN)
      BEAT_ACK && !REQ_DONE |-> BURST_ADDR_OUT == $past(BURST_ADDR_OUT) + 2'h1;
  endproperty
  a_burst_addr_out: assert property (p_burst_addr_out) else $error("burst address stuck");

  // Idle means chip selects, SDRAM row and column strobes, pattern and parity lane selects inactive
  property p_idle;
    @(posedge CLK) disable iff (!RESETN)
      q.st == ST_IDLE |-> CS_N == 8'hff && SDRAM_ROW_STROBE_N && SDRAM_COL_STROBE_N
                          && PROG_LANE_SELECT_N == 8'hff && PARITY_LANE_SELECT_N;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe active while idle");
endmodule

// ===== testbench/emcp_mem_model.sv
// Far-side memory model: acks chip-select accesses, stalls the pattern machine.
// Assumes one clock; the bench sets ack delay and wait length.
module emcp_mem_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] cs_n,
  input  wire logic       rd_en_n,
  input  wire logic [7:0] wr_lane_n,
  input  wire logic [7:0] pg_lane_n,
  input  wire logic [5:0] pg_lines,
  input  wire logic [3:0] ack_dly,
  input  wire logic [3:0] wait_len,
  output logic            ack_n,
  output logic            wait_hi
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] ack_cnt_q;  // Cycles since access start or last ack
  logic [3:0] wait_cnt_q; // Cycles of pattern activity
  logic       gp_act;     // Chip-select access seen on the pins
  logic       pg_act;     // Pattern machine driving the pins
  // Decode activity from the pins
  always_comb begin
    gp_act = (cs_n != 8'hff) && (!rd_en_n || wr_lane_n != 8'hff);
    pg_act = (pg_lane_n != 8'hff) || (pg_lines != 6'h3f);
  end
  // One ack per beat after the delay; the line is driven high otherwise
  assign ack_n   = !(gp_act && ack_cnt_q == ack_dly);
  // Wait stays high for the first cycles of a pattern run
  assign wait_hi = pg_act && (wait_cnt_q < wait_len);
  // Count cycles for both answers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_cnt_q  <= 4'h0;
      wait_cnt_q <= 4'h0;
    end else begin
      ack_cnt_q  <= (gp_act && ack_n) ? ack_cnt_q + 4'h1 : 4'h0;
      wait_cnt_q <= pg_act ? wait_cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the memory controller pin sequencer.
// Assumes the far-side model answers acks and waits; there are no registers.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import emcp_pkg::*;
  logic       clk, resetn, req_valid, req_write, req_burst, pat_we, ext_master, parity_en;
  logic       req_ready, beat_ack, req_done, gp_rd_n, ack_n, wait_hi, ale, par_n, bca, bcb;
  logic       sd_a10, sd_we_n, sd_ras_n, sd_cas_n, sd_mux;
  emcp_mach_t req_mach;
  emcp_pat_t  pat_data;
  logic [2:0] req_bank;
  logic [31:0] req_addr;
  logic [1:0] req_size, req_port, buf_cfg, burst_addr_out;
  logic [5:0] req_pat_start, pat_addr;
  logic [7:0] cs_n, wr_n, sd_mask, pg_n;
  logic [3:0] ack_dly, wait_len;
  wire  [5:0] lines;    // Six pattern lines gathered
  int         n_fail;   // Mismatches seen
  int         n_checks; // Comparisons made
  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare one result, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Print the counts and the verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Step past the next edge so outputs are settled
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Offer one request; returns in the first cycle after it is taken
  task automatic issue(input emcp_mach_t m, input logic w, b, input logic [2:0] bank,
                       input logic [31:0] a, input logic [1:0] sz, pt);
    #1;
    chk(req_ready, 1'b1, "ready");
    @(posedge clk);
    req_valid <= 1'b1;
    req_mach  <= m;
    req_write <= w;
    req_burst <= b;
    req_bank  <= bank;
    req_addr  <= a;
    req_size  <= sz;
    req_port  <= pt;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
  endtask
  // Wait for completion under a bound, counting cycles and beats
  task automatic wait_done(output int cyc, output int beats);
    cyc = 0;
    beats = 0;
    repeat (100) begin
      cyc++;
      if (beat_ack === 1'b1) beats++;
      if (req_done === 1'b1) return;
      tick();
    end
    n_fail++;
    $display("mismatch at %0t: no completion", $time);
    summarize();
  endtask
  // All pins except the buffer controls at their inactive levels
  task automatic idle_chk();
    chk({cs_n, wr_n, pg_n, sd_mask}, 32'hffffffff, "idle lanes");
    chk({gp_rd_n, sd_we_n, sd_ras_n, sd_cas_n, par_n, lines}, 32'h7ff, "idle strobes");
    chk({ale, sd_a10, sd_mux, burst_addr_out}, 32'h0, "idle addr");
  endtask
  // Chip-select access ended by the model's acks
  task automatic gp(input logic w, b, input logic [2:0] bank, input logic [31:0] a,
                    input logic [1:0] sz, pt, input logic [3:0] dly, input logic [1:0] cfg,
                    input logic ext, par, input logic [7:0] lanes_n);
    int cyc;
    int beats;
    ack_dly = dly;
    @(posedge clk);
    ext_master <= ext;
    parity_en  <= par;
    buf_cfg    <= cfg;
    issue(M_GP, w, b, bank, a, sz, pt);
    chk(cs_n, 8'(~(8'h01 << bank)), "gp select");
    chk({gp_rd_n, wr_n}, {w, w ? lanes_n : 8'hff}, "gp strobes");
    chk({ale, par_n, burst_addr_out}, {ext, ~par, a[4:3]}, "gp side");
    chk({bca, bcb}, (cfg == 2'h1) ? {w, ~w} : {w, 1'b0}, "buffers");
    wait_done(cyc, beats);
    chk(cyc, (b ? 4 : 1) * (dly + 1) + 1, "gp length");
    chk(beats, b ? 4 : 1, "gp beats");
    tick();
    idle_chk();
  endtask
  // SDRAM access walked cycle by cycle
  task automatic sd(input logic w, b, input logic [2:0] bank, input logic [31:0] a,
                    input logic [1:0] sz, pt, input logic [7:0] mask);
    int cyc;
    int beats;
    @(posedge clk);
    ext_master <= 1'b1;
    issue(M_SD, w, b, bank, a, sz, pt);
    chk({cs_n, sd_ras_n, sd_a10, burst_addr_out}, {~(8'h01 << bank), 1'b0, a[10], a[4:3]}, "row");
    tick();
    chk(sd_ras_n, 1'b1, "row end");
    tick();
    chk({sd_cas_n, sd_we_n, sd_a10, sd_mux, sd_mask}, {1'b0, ~w, 2'b11, mask}, "column");
    tick();
    wait_done(cyc, beats);
    // Count starts in the cycle after the column command, one before the first beat
    chk(cyc, b ? 5 : 2, "sd length");
    chk(beats, b ? 4 : 1, "sd beats");
    tick();
    idle_chk();
  endtask
  // Write one pattern word
  task automatic load(input logic [5:0] ad, input emcp_pat_t wd);
    @(posedge clk);
    pat_we   <= 1'b1;
    pat_addr <= ad;
    pat_data <= wd;
    @(posedge clk);
    pat_we   <= 1'b0;
  endtask
  // Pattern run with a given wait length
  task automatic pg(input logic [3:0] wl, output int cyc);
    int beats;
    wait_len = wl;
    issue(M_PG, 1'b0, 1'b0, 3'h4, 32'h0, 2'h2, 2'h3);
    chk({cs_n, pg_n, lines}, {8'hef, 8'hf0, 6'h15}, "pattern word 0");
    tick();
    chk(lines, 6'h2a, "pattern word 1");
    wait_done(cyc, beats);
    chk(beats, 1, "pattern beats");
    tick();
    idle_chk();
  endtask
  // Main sequence
  initial begin
    int c0;
    int c4;
    n_fail = 0;
    n_checks = 0;
    resetn = 1'b0;
    {req_valid, req_write, req_burst, pat_we, ext_master, parity_en} = 6'h0;
    req_mach = M_GP;
    pat_data = '0;
    {req_bank, req_addr, req_size, req_port, buf_cfg} = '0;
    req_pat_start = 6'h08;
    pat_addr = 6'h0;
    ack_dly = 4'h0;
    wait_len = 4'h0;
    repeat (10) @(posedge clk);
    #1;
    idle_chk();
    chk({bca, bcb, beat_ack, req_done, req_ready}, 5'b01001, "reset");
    @(posedge clk);
    resetn <= 1'b1;
    load(6'h08, {2'b11, 6'h15, 3'b000});
    load(6'h09, {2'b11, 6'h2a, 3'b110});
    load(6'h0a, {2'b11, 6'h00, 3'b001});
    gp(1'b0, 1'b0, 3'h3, 32'h10, 2'h3, 2'h3, 4'h0, 2'h1, 1'b1, 1'b1, 8'hff);
    gp(1'b1, 1'b0, 3'h5, 32'h0e, 2'h1, 2'h2, 4'h2, 2'h1, 1'b0, 1'b0, 8'hf3);
    gp(1'b1, 1'b1, 3'h0, 32'h18, 2'h3, 2'h3, 4'h1, 2'h0, 1'b1, 1'b1, 8'h00);
    sd(1'b1, 1'b0, 3'h1, 32'h0a, 2'h1, 2'h3, 8'hf3);
    sd(1'b0, 1'b1, 3'h7, 32'h408, 2'h3, 2'h3, 8'h00);
    pg(4'h0, c0);
    pg(4'h4, c4);
    chk(c4 - c0, 3, "wait stall");
    summarize();
  end
  // Far-side memories
  emcp_mem_model u_mem (
    .clk       (clk),
    .resetn    (resetn),
    .cs_n      (cs_n),
    .rd_en_n   (gp_rd_n),
    .wr_lane_n (wr_n),
    .pg_lane_n (pg_n),
    .pg_lines  (lines),
    .ack_dly   (ack_dly),
    .wait_len  (wait_len),
    .ack_n     (ack_n),
    .wait_hi   (wait_hi)
  );
  // Block under test
  emcp_top dut (
    .CLK(clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_MACH(req_mach),
    .REQ_WRITE(req_write), .REQ_BURST(req_burst), .REQ_BANK(req_bank), .REQ_ADDR(req_addr),
    .REQ_SIZE(req_size), .REQ_PORT(req_port), .REQ_PAT_START(req_pat_start), .BEAT_ACK(beat_ack),
    .REQ_DONE(req_done), .PAT_WE(pat_we), .PAT_ADDR(pat_addr), .PAT_DATA(pat_data),
    .EXT_MASTER(ext_master), .PARITY_EN(parity_en), .BUFFER_CTRL_CFG(buf_cfg), .CS_N(cs_n),
    .GP_WRITE_LANE_N(wr_n), .GP_READ_ENABLE_N(gp_rd_n), .GP_XFER_ACK_IN_N(ack_n),
    .SDRAM_LANE_MASK(sd_mask), .SDRAM_ADDR_BIT10(sd_a10), .SDRAM_WRITE_N(sd_we_n),
    .SDRAM_ROW_STROBE_N(sd_ras_n), .SDRAM_COL_STROBE_N(sd_cas_n), .SDRAM_ADDR_MUX_SEL(sd_mux),
    .PROG_LANE_SELECT_N(pg_n), .PROG_LINE_0(lines[0]), .PROG_LINE_1(lines[1]), .PROG_LINE_2(lines[2]),
    .PROG_LINE_3(lines[3]), .PROG_LINE_4(lines[4]), .PROG_LINE_5(lines[5]), .PROG_WAIT_IN(wait_hi),
    .PARITY_LANE_SELECT_N(par_n), .ADDR_LATCH_EN(ale), .BUFFER_CTRL_A(bca), .BUFFER_CTRL_B(bcb),
    .BURST_ADDR_OUT(burst_addr_out)
  );
endmodule
